// File: include/sac_map.svh
// Purpose: constants for the converter sequencer control block
// Assumes: 50 MHz system clock
// Notes:   all offsets, codes and counts live here
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_RES_W        10
`define SAC_WORD_W       16
`define SAC_BUF_DEPTH    16
`define SAC_NUM_IN       16
`define SAC_CLK_MHZ      50
`define SAC_MAX_KSPS     500
// Cycles per sample at the fastest rate, rounded down
`define SAC_MIN_PERIOD_CYC ((`SAC_CLK_MHZ*1000)/`SAC_MAX_KSPS)
`define SAC_TRIG_SW      3'h0
`define SAC_TRIG_AUTO    3'h7
`define SAC_FMT_INT      2'h0
`define SAC_FMT_SINT     2'h1
`define SAC_FMT_FRAC     2'h2
`define SAC_FMT_SFRAC    2'h3
`define SAC_CTL_RST      16'h0000
`endif

// File: include/sac_pkg.sv
// Purpose: types for the converter sequencer control block
// Assumes: sac_map.svh supplies the constants
// Notes:   the first two control register images travel as packed structs
`include "sac_map.svh"
package sac_pkg;
  typedef struct packed {
    logic        converter_on_bit;
    logic [1:0]  result_format;
    logic [2:0]  trigger_source_select;
    logic        auto_sample_bit;
    logic        simultaneous_sample_bit;
  } sac_ctl1_t;
  typedef struct packed {
    logic        ref_select_ext;
    logic [3:0]  samples_per_irq;
    logic        split_buffer_bit;
    logic        alternate_input_bit;
  } sac_ctl2_t;
  typedef enum logic [1:0] {
    SAC_IDLE, SAC_ACQ, SAC_CONV
  } sac_state_t;
endpackage

// File: core/sac_seq.sv
// Purpose: sequencer for a 10-bit successive-approximation converter
// Assumes: control inputs synchronous to clk; comparator supplied outside
// Notes:   one conversion of RES_W steps, results kept in internal buffer
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_seq
  import sac_pkg::*;
#(
  parameter int RES_W  = `SAC_RES_W,
  parameter int DEPTH  = `SAC_BUF_DEPTH,
  parameter int NUM_IN = `SAC_NUM_IN
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Control register images
  input  wire sac_ctl1_t              ctl_one,
  input  wire sac_ctl2_t              ctl_two,
  input  wire logic [15:0]            control_reg_three,
  input  wire logic [15:0]            input_channel_select_reg,
  input  wire logic [15:0]            pin_analog_config_reg,
  input  wire logic [15:0]            scan_input_select_reg,
  input  wire logic                   sample_request_bit,
  input  wire logic                   sample_request_clr,
  input  wire logic                   ext_trigger,
  input  wire logic                   irq_flag_clr,
  input  wire logic                   sleep_mode,
  // Analog front end
  input  wire logic                   comparator_high,
  output logic [RES_W-1:0]            dac_code_ff,
  output logic [3:0]                  mux_input_ff,
  output logic [1:0]                  hold_channel_ff,
  output logic                        hold_sample_ff,
  output logic                        ref_ext_ff,
  output logic [NUM_IN-1:0]           pin_analog_ff,
  // Result read port
  input  wire logic [3:0]             rd_addr,
  input  wire logic                   buf_wr_en,
  output logic [`SAC_WORD_W-1:0]      rd_data_ff,
  // Status
  output logic                        converter_irq_flag_ff,
  output logic                        done_flag_ff,
  output logic                        busy_ff
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fmt_word(input logic [RES_W-1:0] r,
                                           input logic [1:0] f);
    logic [RES_W-1:0] s;
    s = r ^ {1'b1, {(RES_W-1){1'b0}}};
    case (f)
      `SAC_FMT_INT:  fmt_word = {6'h00, r};
      `SAC_FMT_SINT: fmt_word = {{6{s[RES_W-1]}}, s};
      `SAC_FMT_FRAC: fmt_word = {r, 6'h00};
      default:       fmt_word = {s, 6'h00};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sac_state_t             state_ff, nxt_state;
  logic [RES_W-1:0]       sar_ff, nxt_sar;
  logic [3:0]             bit_ff, nxt_bit;
  logic [3:0]             wr_ptr_ff, nxt_wr_ptr;
  logic [3:0]             cnt_ff, nxt_cnt;
  logic [15:0]            pace_ff, nxt_pace;
  logic                   irq_ff, nxt_irq;
  logic                   done_ff, nxt_done;
  logic                   req_d_ff;
  logic [RES_W-1:0]       mem [DEPTH];
  logic                   wr_en;
  logic [RES_W-1:0]       wr_val;
  logic                   trig;
  logic                   start;
  logic                   last_bit;
  logic [RES_W-1:0]       sar_k;

  // Trigger selection; the sleep input is deliberately not used
  always_comb begin
    case (ctl_one.trigger_source_select)
      `SAC_TRIG_SW:   trig = sample_request_clr;
      `SAC_TRIG_AUTO: trig = (pace_ff == 16'h0000);
      default:        trig = ext_trigger;
    endcase
  end

  assign start = sample_request_bit & ~req_d_ff;
  assign last_bit = (bit_ff == 4'h0);
  // Trial bit dropped when the comparator says the code is too high
  assign sar_k = comparator_high ?
                 (sar_ff & ~({{(RES_W-1){1'b0}}, 1'b1} << bit_ff)) :
                 sar_ff;

  always_comb begin
    nxt_state  = state_ff;
    nxt_sar    = sar_ff;
    nxt_bit    = bit_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_cnt    = cnt_ff;
    nxt_pace   = (pace_ff == 16'h0000) ? 16'h0000 : pace_ff - 16'h0001;
    nxt_irq    = irq_ff;
    nxt_done   = done_ff;
    wr_en      = 1'b0;
    wr_val     = {RES_W{1'b0}};
    if (irq_flag_clr) begin
      nxt_irq  = 1'b0;
    end
    if (!ctl_one.converter_on_bit) begin
      nxt_state = SAC_IDLE;
      // Stale counts would shift the next group off the buffer base
      nxt_cnt    = 4'h0;
      nxt_wr_ptr = 4'h0;
    end else begin
      case (state_ff)
        SAC_IDLE: begin
          if (start || ctl_one.auto_sample_bit) begin
            nxt_state = SAC_ACQ;
            nxt_done  = 1'b0;
            if (start) begin
              nxt_irq = 1'b0;
            end
            nxt_pace  = 16'(`SAC_MIN_PERIOD_CYC - RES_W - 2);
          end
        end
        SAC_ACQ: begin
          if (trig && pace_ff == 16'h0000) begin
            nxt_state = SAC_CONV;
            nxt_bit   = 4'(RES_W - 1);
            nxt_sar   = {1'b1, {(RES_W-1){1'b0}}};
          end
        end
        SAC_CONV: begin
          // Trial bit kept or dropped, next bit tried
          nxt_sar = sar_k;
          if (!last_bit) begin
            nxt_bit = bit_ff - 4'h1;
            nxt_sar = sar_k | ({{(RES_W-1){1'b0}}, 1'b1} << (bit_ff - 4'h1));
          end else begin
            wr_en  = 1'b1;
            wr_val = sar_k;
            nxt_wr_ptr = wr_ptr_ff + 4'h1;
            nxt_cnt    = cnt_ff + 4'h1;
            nxt_state  = ctl_one.auto_sample_bit ? SAC_ACQ : SAC_IDLE;
            nxt_pace   = 16'(`SAC_MIN_PERIOD_CYC - RES_W - 2);
            if (cnt_ff == ctl_two.samples_per_irq) begin
              nxt_irq    = 1'b1;
              nxt_done   = 1'b1;
              nxt_cnt    = 4'h0;
              nxt_wr_ptr = 4'h0;
            end
          end
        end
        default: nxt_state = SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff  <= SAC_IDLE;
      sar_ff    <= '0;
      bit_ff    <= 4'h0;
      wr_ptr_ff <= 4'h0;
      cnt_ff    <= 4'h0;
      pace_ff   <= 16'h0000;
      irq_ff    <= 1'b0;
      done_ff   <= 1'b0;
      req_d_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      sar_ff    <= nxt_sar;
      bit_ff    <= nxt_bit;
      wr_ptr_ff <= nxt_wr_ptr;
      cnt_ff    <= nxt_cnt;
      pace_ff   <= nxt_pace;
      irq_ff    <= nxt_irq;
      done_ff   <= nxt_done;
      req_d_ff  <= sample_request_bit;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  // Only the sequencer writes; buf_wr_en from software is ignored
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ptr_ff] <= wr_val;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff            <= 16'h0000;
      dac_code_ff           <= '0;
      mux_input_ff          <= 4'h0;
      hold_channel_ff       <= 2'h0;
      hold_sample_ff        <= 1'b0;
      ref_ext_ff            <= 1'b0;
      pin_analog_ff         <= '0;
      converter_irq_flag_ff <= 1'b0;
      done_flag_ff          <= 1'b0;
      busy_ff               <= 1'b0;
    end else begin
      rd_data_ff <= fmt_word(mem[rd_addr], ctl_one.result_format);
      dac_code_ff     <= nxt_sar;
      // Alternate mux group taken from upper byte on odd samples
      mux_input_ff    <= (ctl_two.alternate_input_bit && cnt_ff[0]) ?
                         input_channel_select_reg[11:8] :
                         input_channel_select_reg[3:0];
      hold_channel_ff <= 2'h0;
      hold_sample_ff  <= (nxt_state == SAC_ACQ);
      ref_ext_ff      <= ctl_two.ref_select_ext;
      pin_analog_ff   <= ~pin_analog_config_reg[NUM_IN-1:0];
      converter_irq_flag_ff <= nxt_irq;
      done_flag_ff    <= nxt_done;
      busy_ff         <= (nxt_state != SAC_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Conversion length monitor
  // ----------------------------------------------------------------
  // Counts converting cycles so the length check needs no long
  // repetition; saturates so a stuck conversion cannot wrap back
  logic [3:0]             conv_cyc_ff, nxt_conv_cyc;

  always_comb begin
    nxt_conv_cyc = 4'h0;
    if (nxt_state == SAC_CONV) begin
      nxt_conv_cyc = (conv_cyc_ff == 4'hF) ? 4'hF : conv_cyc_ff + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_cyc_ff <= 4'h0;
    end else begin
      conv_cyc_ff <= nxt_conv_cyc;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_on_count_a: assert property (@(posedge clk) disable iff (rst)
    $rose(irq_ff) |-> $past(cnt_ff) == $past(ctl_two.samples_per_irq))
    else $error("irq flag before sample count");
  ptr_to_base_a: assert property (@(posedge clk) disable iff (rst)
    $rose(done_ff) |-> wr_ptr_ff == 4'h0)
    else $error("write pointer not at base");
  abort_idle_a: assert property (@(posedge clk) disable iff (rst)
    !ctl_one.converter_on_bit |=> state_ff == SAC_IDLE)
    else $error("no abort when turned off");
  conv_len_a: assert property (@(posedge clk) disable iff (rst)
    wr_en |-> conv_cyc_ff == 4'(RES_W))
    else $error("conversion length wrong");
  conv_max_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == SAC_CONV |-> conv_cyc_ff <= 4'(RES_W))
    else $error("conversion runs too long");
  start_acq_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == SAC_IDLE && start && ctl_one.converter_on_bit
    |=> state_ff == SAC_ACQ)
    else $error("sample request ignored");
  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    irq_ff && !irq_flag_clr && !(start && state_ff == SAC_IDLE) |=> irq_ff)
    else $error("irq flag dropped");
  write_on_done_a: assert property (@(posedge clk) disable iff (rst)
    wr_en |-> state_ff == SAC_CONV && last_bit)
    else $error("buffer write out of place");
  sw_trig_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == SAC_ACQ && ctl_one.converter_on_bit && trig
    && pace_ff == 16'h0000 |=> state_ff == SAC_CONV)
    else $error("trigger did not convert");
  conv_c: cover property (@(posedge clk) disable iff (rst) wr_en);
  irq_c: cover property (@(posedge clk) disable iff (rst) $rose(irq_ff));
  abort_c: cover property (@(posedge clk) disable iff (rst)
    state_ff == SAC_CONV && !ctl_one.converter_on_bit);
  ext_conv_c: cover property (@(posedge clk) disable iff (rst)
    state_ff == SAC_ACQ && ext_trigger ##1 state_ff == SAC_CONV);

endmodule // sac_seq

// File: verification/sac_analog_model.sv
// Purpose: analog source and comparator seen by the sequencer
// Assumes: held input level is steady for a whole conversion
// Notes:   ideal comparator, no offset or noise modelled
`timescale 1ns/1ps
module sac_analog_model (
  // Trial code from the sequencer
  input  wire logic [9:0] dac_code,
  // Held analog level, as an ideal code
  input  wire logic [9:0] level,
  // Comparator answer
  output logic            comparator_high
);
  // -------------------------------------------------------------------
  // Comparator
  // -------------------------------------------------------------------
  // Answers at once, so a slow comparator is not covered here
  assign comparator_high = (dac_code > level);
endmodule // sac_analog_model

// File: verification/sac_seq_tb_top.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: pacing of 100 cycles is fixed inside the design
// Notes:   config fields change only while the converter is off
`timescale 1ns/1ps
module sac_seq_tb_top
  import sac_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  sac_ctl1_t   c1;
  sac_ctl2_t   c2;
  logic [15:0] r3, chs, pcfg, scan, rdd, pa;
  logic        req, req_clr, ext_trig, irq_clr, sleep, wr_en, comp;
  logic        hs, refx, irq, done, busy;
  logic [3:0]  rd_addr, mux;
  logic [1:0]  hch;
  logic [9:0]  level, dac;
  int          n_errors = 0;
  int          checked = 0;
  always #10 clk = ~clk;
  sac_seq dut (.clk(clk), .rst(rst), .ctl_one(c1), .ctl_two(c2),
    .control_reg_three(r3), .input_channel_select_reg(chs),
    .pin_analog_config_reg(pcfg), .scan_input_select_reg(scan),
    .sample_request_bit(req), .sample_request_clr(req_clr),
    .ext_trigger(ext_trig), .irq_flag_clr(irq_clr), .sleep_mode(sleep),
    .comparator_high(comp), .dac_code_ff(dac), .mux_input_ff(mux),
    .hold_channel_ff(hch), .hold_sample_ff(hs), .ref_ext_ff(refx),
    .pin_analog_ff(pa), .rd_addr(rd_addr), .buf_wr_en(wr_en),
    .rd_data_ff(rdd), .converter_irq_flag_ff(irq), .done_flag_ff(done),
    .busy_ff(busy));
  sac_analog_model src (.dac_code(dac), .level(level),
    .comparator_high(comp));
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    rd_addr = a;
    repeat (2) @(negedge clk);
    cmp("rd_data", exp, rdd);
  endtask
  // Only touched while off: mode fields are unsafe while running
  task automatic setup(logic [3:0] n);
    c1.converter_on_bit = 1'b0;
    @(negedge clk) c2.samples_per_irq = n;
    @(negedge clk) c1.converter_on_bit = 1'b1;
    irq_clr = 1'b1;
    @(negedge clk) irq_clr = 1'b0;
  endtask
  task automatic start_trig(logic [9:0] v);
    level = v;
    @(negedge clk) req = 1'b1;
    repeat (3) @(negedge clk);
    cmp("hold_sample", 16'h1, hs);
    cmp("mux_input", 16'h5, mux);
    repeat (37) @(negedge clk);
    // An early trigger must be lost, or the rate limit is broken
    req_clr = 1'b1;
    @(negedge clk) req_clr = 1'b0;
    repeat (2) @(negedge clk);
    cmp("hold_early", 16'h1, hs);
    repeat (55) @(negedge clk);
    req_clr = 1'b1;
    req = 1'b0;
    @(negedge clk) req_clr = 1'b0;
  endtask
  task automatic convert(logic [9:0] v);
    int i;
    start_trig(v);
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    cmp("busy_end", 16'h0, busy);
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_static();
    c2.ref_select_ext = 1'b1;
    pcfg = 16'h00F0;
    repeat (2) @(negedge clk);
    cmp("ref_ext", 16'h1, refx);
    cmp("pin_analog", 16'hFF0F, pa);
  endtask
  task automatic t_single();
    setup(4'h0);
    convert(10'h2A7);
    cmp("irq", 16'h1, irq);
    cmp("done", 16'h1, done);
    rd(4'h0, 16'h02A7);
  endtask
  task automatic t_group();
    setup(4'h1);
    sleep = 1'b1;
    convert(10'h3FF);
    cmp("done_half", 16'h0, done);
    convert(10'h001);
    cmp("done_full", 16'h1, done);
    rd(4'h0, 16'h03FF);
    rd(4'h1, 16'h0001);
    irq_clr = 1'b1;
    @(negedge clk) irq_clr = 1'b0;
    @(negedge clk);
    cmp("irq_clr", 16'h0, irq);
    cmp("done_hold", 16'h1, done);
    sleep = 1'b0;
    convert(10'h155);
    rd(4'h0, 16'h0155);
  endtask
  task automatic t_abort();
    setup(4'h0);
    start_trig(10'h0AA);
    repeat (4) @(negedge clk);
    c1.converter_on_bit = 1'b0;
    wr_en = 1'b1;
    repeat (3) @(negedge clk);
    cmp("busy_abort", 16'h0, busy);
    cmp("done_abort", 16'h0, done);
    rd(4'h0, 16'h0155);
    wr_en = 1'b0;
  endtask
  // External trigger held early must still wait out the pacing
  task automatic t_ext();
    int i;
    c1.trigger_source_select = 3'h2;
    setup(4'h0);
    level = 10'h0F0;
    @(negedge clk);
    req = 1'b1;
    ext_trig = 1'b1;
    repeat (50) @(negedge clk);
    cmp("hold_ext", 16'h1, hs);
    for (i = 0; i < 80 && busy !== 1'b0; i++) @(negedge clk);
    cmp("busy_ext", 16'h0, busy);
    cmp("done_ext", 16'h1, done);
    rd(4'h0, 16'h00F0);
    req = 1'b0;
    ext_trig = 1'b0;
  endtask
  // -------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    c1 = '0;
    c2 = '0;
    r3 = 16'h0000;
    scan = 16'h0000;
    chs = 16'h0A05;
    pcfg = 16'h0000;
    {req, req_clr, ext_trig, irq_clr, sleep, wr_en} = 6'h00;
    rd_addr = 4'h0;
    level = 10'h000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cmp("busy_rst", 16'h0, busy);
    cmp("irq_rst", 16'h0, irq);
    t_static();
    t_single();
    t_group();
    t_abort();
    t_ext();
    complete_run();
  end
  // Whole run needs about 690 cycles
  initial begin
    #60000;
    n_errors++;
    complete_run();
  end
endmodule // sac_seq_tb_top
